// file: common/ddrinit_pkg.sv
// ddr2 init sequencer: offsets, field positions, reset values
// assumes byte offsets on an 8-bit register address
package ddrinit_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_ID = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_RFC = 8'h0C;
  localparam logic [7:0] OFS_TIM1 = 8'h10;
  localparam logic [7:0] OFS_TIM2 = 8'h14;
  localparam logic [7:0] OFS_CTL = 8'hE4;
  // ----------------------------------------
  // reset values and write masks
  // ----------------------------------------
  // id value is arbitrary
  localparam logic [31:0] ID_VALUE = 32'h0001_0001;
  localparam logic [31:0] CFG_RST = 32'h0053_0A20;
  localparam logic [31:0] CFG_LO_WMASK = 32'h0000_CE77;
  localparam logic [31:0] RFC_RST = 32'h0000_0800;
  localparam logic [31:0] RFC_WMASK = 32'h8000_FFFF;
  localparam logic [31:0] TIM1_RST = 32'h42DB_0000;
  localparam logic [31:0] TIM2_RST = 32'h0000_0000;
  localparam logic [31:0] CTL_RST = 32'h0000_0026;
  localparam logic [31:0] CTL_WMASK = 32'h0000_0027;
  localparam logic [31:0] STAT_FIXED = 32'h4000_0000;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_BOOT_GATE = 23;
  localparam int CFG_DRIVE = 18;
  localparam int CFG_TIM_GATE = 15;
  localparam int CFG_WIDTH = 14;
  localparam int CFG_CL_LSB = 9;
  localparam int TIM1_RFC_LSB = 25;
  localparam int TIM1_RP_LSB = 22;
  localparam int TIM1_WR_LSB = 16;
  localparam int CTL_RL_LSB = 0;
  localparam int CTL_IFRST = 5;
  localparam int STAT_RDY = 2;
  localparam int EMR1_DRV = 1;
  // ----------------------------------------
  // memory commands and mode words
  // ----------------------------------------
  localparam logic [2:0] CMD_PRE = 3'h1;
  localparam logic [2:0] CMD_REF = 3'h2;
  localparam logic [2:0] CMD_MRS = 3'h3;
  localparam logic [2:0] BA_MR = 3'h0;
  localparam logic [2:0] BA_EMR1 = 3'h1;
  localparam logic [2:0] BA_EMR2 = 3'h2;
  localparam logic [2:0] BA_EMR3 = 3'h3;
  localparam logic [12:0] ADDR_PRE_ALL = 13'h0400;
  localparam logic [12:0] EMR1_BASE = 13'h0004;
  localparam logic [2:0] MR_BL8 = 3'h3;
  // ----------------------------------------
  // timing counts, memory clock ticks
  // ----------------------------------------
  localparam logic [15:0] INIT_CKE_TICKS = 16'h00C8;
  localparam logic [15:0] T_MRD_TICKS = 16'h0002;
  typedef enum logic [3:0] {
    S_IDLE, S_DRAIN, S_CKE, S_GAP, S_PRE1, S_EMR2, S_EMR3,
    S_EMR1, S_MR, S_PRE2, S_REF1, S_REF2
  } ddrinit_state_t;
endpackage : ddrinit_pkg

// file: common/ddrinit_seq_if.sv
// ddr2 init sequencer: link between register side and sequencer
// assumes one clock domain on both sides
`timescale 1ns/1ps
`default_nettype none
interface ddrinit_seq_if;
  logic tick;
  logic start;
  logic pending;
  logic drive;
  logic [2:0] cas;
  logic [2:0] t_rp;
  logic [2:0] t_wr;
  logic [6:0] t_rfc;
  logic busy;
  logic cmd_v;
  logic cke;
  logic [2:0] cmd;
  logic [2:0] ba;
  logic [12:0] addr;
  modport seq (input tick, start, pending, drive, cas, t_rp, t_wr,
    t_rfc, output busy, cmd_v, cke, cmd, ba, addr);
  modport ctl (output tick, start, pending, drive, cas, t_rp, t_wr,
    t_rfc, input busy, cmd_v, cke, cmd, ba, addr);
endinterface : ddrinit_seq_if
`default_nettype wire

// file: design/ddrinit_seq.sv
// ddr2 init sequencer: power-up and mode register command walk
// assumes tick is a one-cycle memory clock edge strobe
`timescale 1ns/1ps
`default_nettype none
module ddrinit_seq (
  input wire logic clk,
  input wire logic rst,
  ddrinit_seq_if.seq b
);
  typedef struct packed {
    ddrinit_pkg::ddrinit_state_t st;
    ddrinit_pkg::ddrinit_state_t nxt;
    logic [15:0] cnt;
    logic busy;
    logic cmd_v;
    logic cke;
    logic [2:0] cmd;
    logic [2:0] ba;
    logic [12:0] addr;
  } ddrinit_seq_t;
  localparam ddrinit_seq_t SEQ_RST = '{st: ddrinit_pkg::S_CKE,
    nxt: ddrinit_pkg::S_IDLE, cnt: ddrinit_pkg::INIT_CKE_TICKS,
    busy: 1'b1, cmd_v: 1'b0, cke: 1'b0, cmd: 3'h0, ba: 3'h0,
    addr: 13'h0000};
  ddrinit_seq_t q;
  ddrinit_seq_t d;
  logic [2:0] c_cmd;
  logic [2:0] c_ba;
  logic [12:0] c_addr;
  logic [15:0] c_gap;
  ddrinit_pkg::ddrinit_state_t c_nxt;
  logic [12:0] emr1;
  // ----------------------------------------
  // command table per state
  // ----------------------------------------
  always_comb begin
    emr1 = ddrinit_pkg::EMR1_BASE;
    emr1[ddrinit_pkg::EMR1_DRV] = b.drive;
    c_cmd = ddrinit_pkg::CMD_MRS;
    c_ba = ddrinit_pkg::BA_MR;
    c_addr = 13'h0000;
    c_gap = ddrinit_pkg::T_MRD_TICKS;
    c_nxt = ddrinit_pkg::S_IDLE;
    case (q.st)
      ddrinit_pkg::S_PRE1, ddrinit_pkg::S_PRE2: begin
        c_cmd = ddrinit_pkg::CMD_PRE;
        c_addr = ddrinit_pkg::ADDR_PRE_ALL;
        c_gap = {13'h0000, b.t_rp};
        c_nxt = (q.st == ddrinit_pkg::S_PRE1) ?
          ddrinit_pkg::S_EMR2 : ddrinit_pkg::S_REF1;
      end
      ddrinit_pkg::S_EMR2: begin
        c_ba = ddrinit_pkg::BA_EMR2;
        c_nxt = ddrinit_pkg::S_EMR3;
      end
      ddrinit_pkg::S_EMR3: begin
        c_ba = ddrinit_pkg::BA_EMR3;
        c_nxt = ddrinit_pkg::S_EMR1;
      end
      ddrinit_pkg::S_EMR1: begin
        c_ba = ddrinit_pkg::BA_EMR1;
        c_addr = emr1;
        c_nxt = ddrinit_pkg::S_MR;
      end
      ddrinit_pkg::S_MR: begin
        c_addr = {1'b0, b.t_wr, 2'b00, b.cas, 1'b0, ddrinit_pkg::MR_BL8};
        c_nxt = ddrinit_pkg::S_PRE2;
      end
      ddrinit_pkg::S_REF1, ddrinit_pkg::S_REF2: begin
        c_cmd = ddrinit_pkg::CMD_REF;
        c_gap = {9'h000, b.t_rfc};
        c_nxt = (q.st == ddrinit_pkg::S_REF1) ?
          ddrinit_pkg::S_REF2 : ddrinit_pkg::S_IDLE;
      end
      default: ;
    endcase
  end
  // ----------------------------------------
  // sequence walk
  // ----------------------------------------
  always_comb begin
    d = q;
    d.cmd_v = 1'b0;
    if (b.start) begin
      // restart wins: new configuration must reach the memory
      d.st = ddrinit_pkg::S_DRAIN;
      d.busy = 1'b1;
    end else begin
      case (q.st)
        ddrinit_pkg::S_IDLE: d.busy = 1'b0;
        ddrinit_pkg::S_DRAIN: begin
          if (b.tick && !b.pending) begin
            d.st = ddrinit_pkg::S_CKE;
            d.cke = 1'b0;
            d.cnt = ddrinit_pkg::INIT_CKE_TICKS;
          end
        end
        ddrinit_pkg::S_CKE: begin
          if (b.tick && q.cnt == 16'h0000) begin
            d.cke = 1'b1;
            d.st = ddrinit_pkg::S_PRE1;
          end else if (b.tick) begin
            d.cnt = q.cnt - 16'h0001;
          end
        end
        ddrinit_pkg::S_GAP: begin
          if (b.tick && q.cnt == 16'h0000) begin
            d.st = q.nxt;
            d.busy = (q.nxt != ddrinit_pkg::S_IDLE);
          end else if (b.tick) begin
            d.cnt = q.cnt - 16'h0001;
          end
        end
        default: begin
          if (b.tick) begin
            d.cmd_v = 1'b1;
            d.cmd = c_cmd;
            d.ba = c_ba;
            d.addr = c_addr;
            d.cnt = c_gap;
            d.nxt = c_nxt;
            d.st = ddrinit_pkg::S_GAP;
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= SEQ_RST;
    end else begin
      q <= d;
    end
  end
  assign b.busy = q.busy;
  assign b.cmd_v = q.cmd_v;
  assign b.cke = q.cke;
  assign b.cmd = q.cmd;
  assign b.ba = q.ba;
  assign b.addr = q.addr;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_emr1_word;
    @(posedge clk) disable iff (rst)
    q.cmd_v && q.cmd == ddrinit_pkg::CMD_MRS && q.ba == 3'h1
      |-> q.addr[12:2] == 11'h001 && !q.addr[0] && q.addr[1] == b.drive;
  endproperty
  a_emr1_word: assert property (p_emr1_word)
    else $error("emr1 word wrong");
  property p_emr23_zero;
    @(posedge clk) disable iff (rst)
    q.cmd_v && q.cmd == ddrinit_pkg::CMD_MRS && q.ba[1] |-> q.addr == 0;
  endproperty
  a_emr23_zero: assert property (p_emr23_zero)
    else $error("emr2 or emr3 not zero");
  property p_drain_hold;
    @(posedge clk) disable iff (rst)
    q.st == ddrinit_pkg::S_DRAIN && b.pending
      |=> q.st == ddrinit_pkg::S_DRAIN && !q.cmd_v;
  endproperty
  a_drain_hold: assert property (p_drain_hold)
    else $error("init began with work pending");
  a_cov_emr1: cover property (@(posedge clk) disable iff (rst)
    q.cmd_v && q.ba == ddrinit_pkg::BA_EMR1);
endmodule : ddrinit_seq
`default_nettype wire

// file: design/ddrinit_top.sv
// ddr2 init sequencer top: register port, link clock sampling,
// read capture timing and the init sequencer instance
// assumes register port and queue status on clk; mem_clk_in async
`timescale 1ns/1ps
`default_nettype none
module ddrinit_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic mem_clk_in,
  input wire logic queue_pending,
  output logic req_ready,
  input wire logic rd_issue,
  output logic rd_capture,
  output logic mem_cmd_valid,
  output logic [2:0] mem_cmd,
  output logic [2:0] mem_ba,
  output logic [12:0] mem_addr,
  output logic mem_cke,
  output logic init_busy,
  output logic bus_width_select,
  output logic [2:0] read_sample_latency,
  output logic interface_logic_reset,
  output logic [15:0] refresh_interval
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_p;
    logic [31:0] cfg;
    logic [31:0] rfc;
    logic [31:0] tim1;
    logic [31:0] tim2;
    logic [31:0] ctl;
    logic [31:0] rdata;
    logic start;
    logic ready;
    logic rd_cap;
    logic [2:0] rd_cnt;
  } ddrinit_top_t;
  localparam ddrinit_top_t TOP_RST = '{lclk_s1: 1'b0, lclk_s2: 1'b0,
    lclk_p: 1'b0, cfg: ddrinit_pkg::CFG_RST,
    rfc: ddrinit_pkg::RFC_RST, tim1: ddrinit_pkg::TIM1_RST,
    tim2: ddrinit_pkg::TIM2_RST, ctl: ddrinit_pkg::CTL_RST,
    rdata: 32'h0000_0000, start: 1'b0, ready: 1'b0, rd_cap: 1'b0,
    rd_cnt: 3'h0};
  ddrinit_top_t q;
  ddrinit_top_t d;
  ddrinit_seq_if b ();
  logic sm_rst;
  logic tick;
  logic if_rdy;
  // soft reset reaches the sequencer, the start pulse and the read count, never the registers
  assign sm_rst = rst | soft_rst;
  // ----------------------------------------
  // link clock edge, seen through two flops
  // ----------------------------------------
  assign tick = q.lclk_s2 & ~q.lclk_p;
  assign if_rdy = ~q.ctl[ddrinit_pkg::CTL_IFRST] & ~b.busy;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.lclk_s1 = mem_clk_in;
    d.lclk_s2 = q.lclk_s1;
    d.lclk_p = q.lclk_s2;
    d.start = 1'b0;
    d.rdata = 32'h0000_0000;
    d.rd_cap = 1'b0;
    // held low one cycle early so no request slips in beside start
    d.ready = ~b.busy & ~q.start;
    if (reg_wr) begin
      case (reg_addr)
        ddrinit_pkg::OFS_CFG: begin
          d.cfg[ddrinit_pkg::CFG_BOOT_GATE] =
            reg_wdata[ddrinit_pkg::CFG_BOOT_GATE];
          if (q.cfg[ddrinit_pkg::CFG_BOOT_GATE]) begin
            d.cfg[ddrinit_pkg::CFG_DRIVE] =
              reg_wdata[ddrinit_pkg::CFG_DRIVE];
          end
          d.cfg = (d.cfg & ~ddrinit_pkg::CFG_LO_WMASK) |
            (reg_wdata & ddrinit_pkg::CFG_LO_WMASK);
          // port is word wide, so every write hits the low bytes
          d.start = 1'b1;
        end
        ddrinit_pkg::OFS_RFC: begin
          d.rfc = reg_wdata & ddrinit_pkg::RFC_WMASK;
        end
        ddrinit_pkg::OFS_TIM1: begin
          if (q.cfg[ddrinit_pkg::CFG_TIM_GATE]) begin
            d.tim1 = reg_wdata;
          end
        end
        ddrinit_pkg::OFS_TIM2: begin
          if (q.cfg[ddrinit_pkg::CFG_TIM_GATE]) begin
            d.tim2 = reg_wdata;
          end
        end
        ddrinit_pkg::OFS_CTL: begin
          d.ctl = reg_wdata & ddrinit_pkg::CTL_WMASK;
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ddrinit_pkg::OFS_ID: d.rdata = ddrinit_pkg::ID_VALUE;
        ddrinit_pkg::OFS_STAT: begin
          d.rdata = ddrinit_pkg::STAT_FIXED;
          d.rdata[ddrinit_pkg::STAT_RDY] = if_rdy;
        end
        ddrinit_pkg::OFS_CFG: d.rdata = q.cfg;
        ddrinit_pkg::OFS_RFC: d.rdata = q.rfc;
        ddrinit_pkg::OFS_TIM1: d.rdata = q.tim1;
        ddrinit_pkg::OFS_TIM2: d.rdata = q.tim2;
        ddrinit_pkg::OFS_CTL: d.rdata = q.ctl;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    // one read in flight; a new issue restarts the count
    if (rd_issue) begin
      d.rd_cnt = q.ctl[ddrinit_pkg::CTL_RL_LSB +: 3];
    end else if (tick && q.rd_cnt != 3'h0) begin
      d.rd_cnt = q.rd_cnt - 3'h1;
      d.rd_cap = (q.rd_cnt == 3'h1);
    end
    if (soft_rst) begin
      d.start = 1'b0;
      d.rd_cnt = 3'h0;
      d.rd_cap = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign b.tick = tick;
  assign b.start = q.start;
  assign b.pending = queue_pending;
  assign b.drive = q.cfg[ddrinit_pkg::CFG_DRIVE];
  assign b.cas = q.cfg[ddrinit_pkg::CFG_CL_LSB +: 3];
  assign b.t_rp = q.tim1[ddrinit_pkg::TIM1_RP_LSB +: 3];
  assign b.t_wr = q.tim1[ddrinit_pkg::TIM1_WR_LSB +: 3];
  assign b.t_rfc = q.tim1[ddrinit_pkg::TIM1_RFC_LSB +: 7];
  ddrinit_seq u_seq (
    .clk(clk),
    .rst(sm_rst),
    .b(b.seq)
  );
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // no interrupt, dma event or debug halt input exists here
  assign reg_rdata = q.rdata;
  assign req_ready = q.ready;
  assign rd_capture = q.rd_cap;
  assign mem_cmd_valid = b.cmd_v;
  assign mem_cmd = b.cmd;
  assign mem_ba = b.ba;
  assign mem_addr = b.addr;
  assign mem_cke = b.cke;
  assign init_busy = b.busy;
  assign bus_width_select = q.cfg[ddrinit_pkg::CFG_WIDTH];
  assign read_sample_latency = q.ctl[ddrinit_pkg::CTL_RL_LSB +: 3];
  assign interface_logic_reset = q.ctl[ddrinit_pkg::CTL_IFRST];
  assign refresh_interval = q.rfc[15:0];
  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [7:0] hlp_ticks;
  always_ff @(posedge clk) begin
    if (rst || rd_issue) begin
      hlp_ticks <= 8'h00;
    end else if (tick && hlp_ticks != 8'hFF) begin
      hlp_ticks <= hlp_ticks + 8'h01;
    end
  end
  property p_reset_init;
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> init_busy [*8];
  endproperty
  a_reset_init: assert property (p_reset_init)
    else $error("no init after reset");
  property p_soft_keep;
    @(posedge clk) disable iff (rst)
    soft_rst && !reg_wr |=> $stable(q.cfg) && $stable(q.tim1)
      && $stable(q.tim2) && init_busy;
  endproperty
  a_soft_keep: assert property (p_soft_keep)
    else $error("soft reset touched registers");
  property p_cfg_start;
    @(posedge clk) disable iff (rst)
    reg_wr && reg_addr == ddrinit_pkg::OFS_CFG |-> ##2 init_busy;
  endproperty
  a_cfg_start: assert property (p_cfg_start)
    else $error("config write did not start init");
  property p_boot_gate;
    @(posedge clk) disable iff (rst)
    reg_wr && reg_addr == ddrinit_pkg::OFS_CFG
      && !q.cfg[ddrinit_pkg::CFG_BOOT_GATE]
      |=> q.cfg[22:16] == $past(q.cfg[22:16]);
  endproperty
  a_boot_gate: assert property (p_boot_gate)
    else $error("boot field written while locked");
  property p_tim_gate;
    @(posedge clk) disable iff (rst)
    reg_wr && !q.cfg[ddrinit_pkg::CFG_TIM_GATE]
      |=> $stable(q.tim1) && $stable(q.tim2);
  endproperty
  a_tim_gate: assert property (p_tim_gate)
    else $error("timing written while locked");
  property p_hold_req;
    @(posedge clk) disable iff (rst)
    init_busy |=> !req_ready;
  endproperty
  a_hold_req: assert property (p_hold_req)
    else $error("request accepted during init");
  property p_capture;
    @(posedge clk) disable iff (rst)
    rd_capture |-> hlp_ticks == {5'h00, read_sample_latency};
  endproperty
  a_capture: assert property (p_capture)
    else $error("read captured in wrong cycle");
  a_cov_reg_init: cover property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == ddrinit_pkg::OFS_CFG ##[1:900] !init_busy);
  a_cov_capture: cover property (@(posedge clk) disable iff (rst)
    rd_capture);
  a_cov_drain: cover property (@(posedge clk) disable iff (rst)
    init_busy && queue_pending ##1 init_busy && !queue_pending);
endmodule : ddrinit_top
`default_nettype wire

// file: testbench/ddrinit_mem_model.sv
// ddr2 memory stand-in: keeps the mode words it is sent and counts
// commands; assumes one-cycle command valid pulses on clk
`timescale 1ns/1ps
`default_nettype none
module ddrinit_mem_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd,
  input wire logic [2:0] ba,
  input wire logic [12:0] addr,
  input wire logic cke,
  output var logic [12:0] mode_q [4],
  output var int ref_cnt,
  output var int cmd_cnt,
  output var int bad_cnt
);
  // ----------------------------------------
  // command capture
  // ----------------------------------------
  // cleared words read all ones, so a skipped mode set is never missed
  always @(posedge clk) begin
    if (clr) begin
      for (int i = 0; i < 4; i++) mode_q[i] <= 13'h1fff;
      ref_cnt <= 0;
      cmd_cnt <= 0;
      bad_cnt <= 0;
    end else if (cmd_valid) begin
      cmd_cnt <= cmd_cnt + 1;
      if (cke !== 1'b1) bad_cnt <= bad_cnt + 1;
      if (cmd == ddrinit_pkg::CMD_MRS) mode_q[ba[1:0]] <= addr;
      if (cmd == ddrinit_pkg::CMD_REF) ref_cnt <= ref_cnt + 1;
    end
  end
endmodule : ddrinit_mem_model
`default_nettype wire

// file: testbench/testbench.sv
// ddr2 init sequencer bench: register walks, init checks, capture
// assumes ddrinit_top and the memory stand-in model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic clr = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic mem_clk_in = 1'b0;
  logic queue_pending = 1'b0;
  logic rd_issue = 1'b0;
  logic [31:0] reg_rdata;
  logic req_ready, rd_capture, mem_cmd_valid, mem_cke, init_busy;
  logic [2:0] mem_cmd, mem_ba, read_sample_latency;
  logic [12:0] mem_addr;
  logic bus_width_select, interface_logic_reset;
  logic [15:0] refresh_interval;
  logic [12:0] mode_q [4];
  int ref_cnt, cmd_cnt, bad_cnt, n, e0, edge_cnt;
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] exp_q [$];
  logic rd_q = 1'b0;
  logic [31:0] rfc_v, t1;
  logic [2:0] twr;
  // ----------------------------------------
  // clocks and instances
  // ----------------------------------------
  always #5 clk = ~clk;
  always #62.5 mem_clk_in = ~mem_clk_in;
  always @(posedge mem_clk_in) edge_cnt++;
  ddrinit_top u_dut (.clk(clk), .rst(rst), .soft_rst(soft_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_clk_in(mem_clk_in),
    .queue_pending(queue_pending), .req_ready(req_ready),
    .rd_issue(rd_issue), .rd_capture(rd_capture),
    .mem_cmd_valid(mem_cmd_valid), .mem_cmd(mem_cmd), .mem_ba(mem_ba),
    .mem_addr(mem_addr), .mem_cke(mem_cke), .init_busy(init_busy),
    .bus_width_select(bus_width_select),
    .read_sample_latency(read_sample_latency),
    .interface_logic_reset(interface_logic_reset),
    .refresh_interval(refresh_interval));
  ddrinit_mem_model u_mem (.clk(clk), .clr(clr), .cmd_valid(mem_cmd_valid),
    .cmd(mem_cmd), .ba(mem_ba), .addr(mem_addr), .cke(mem_cke),
    .mode_q(mode_q), .ref_cnt(ref_cnt), .cmd_cnt(cmd_cnt),
    .bad_cnt(bad_cnt));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  // fixed lead-in only covers the start latency, not the init itself
  task automatic wait_idle();
    int i;
    repeat (4) @(posedge clk);
    for (i = 0; i < 6000 && init_busy !== 1'b0; i++) @(posedge clk);
    if (i == 6000) begin
      err_total++;
      test_done();
    end
  endtask : wait_idle
  task automatic check_init(input logic drv, input logic [2:0] wr_t);
    // ready rises one cycle after busy falls
    @(posedge clk);
    check(32'(mode_q[1][12:7]), 32'h0000_0000);
    check(32'(mode_q[1][6:2]), 32'h0000_0001);
    check(32'(mode_q[1][1:0]), {30'h0, drv, 1'h0});
    check(32'(mode_q[2]), 32'h0000_0000);
    check(32'(mode_q[3]), 32'h0000_0000);
    check(32'(mode_q[0]), {19'h0, 1'h0, wr_t, 2'h0, 3'h5, 4'h3});
    check(32'(bad_cnt), 32'h0000_0000);
    check(32'(ref_cnt), 32'h0000_0002);
    check({31'h0, req_ready}, 32'h0000_0001);
  endtask : check_init
  task automatic wipe();
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
  endtask : wipe
  always @(posedge clk) begin
    if (rd_q) check(reg_rdata, exp_q.pop_front());
    rd_q <= reg_rd;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    n = $urandom(60922);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    rd(ddrinit_pkg::OFS_CFG, ddrinit_pkg::CFG_RST);
    rd(ddrinit_pkg::OFS_RFC, ddrinit_pkg::RFC_RST);
    rd(ddrinit_pkg::OFS_TIM2, ddrinit_pkg::TIM2_RST);
    rd(ddrinit_pkg::OFS_CTL, ddrinit_pkg::CTL_RST);
    rd(ddrinit_pkg::OFS_ID, ddrinit_pkg::ID_VALUE);
    rd(8'h20, 32'h0000_0000);
    rd(ddrinit_pkg::OFS_STAT, 32'h4000_0000);
    wait_idle();
    check_init(1'b0, 3'h3);
    twr = 3'($urandom_range(7, 0));
    rfc_v = {16'h0000, 16'($urandom)};
    t1 = ddrinit_pkg::TIM1_RST;
    t1[18:16] = twr;
    wr(ddrinit_pkg::OFS_CFG, 32'h0057_0A20);
    rd(ddrinit_pkg::OFS_CFG, 32'h0053_0A20);
    wr(ddrinit_pkg::OFS_TIM1, t1);
    wr(ddrinit_pkg::OFS_CFG, 32'h00D3_0A20);
    wr(ddrinit_pkg::OFS_CFG, 32'h0057_0A20);
    wr(ddrinit_pkg::OFS_CFG, 32'h0057_8A20);
    wr(ddrinit_pkg::OFS_TIM1, t1);
    wr(ddrinit_pkg::OFS_TIM2, rfc_v);
    wr(ddrinit_pkg::OFS_RFC, rfc_v);
    wr(ddrinit_pkg::OFS_CFG, 32'h0057_4A20);
    wr(ddrinit_pkg::OFS_CTL, 32'h0000_0006);
    wipe();
    wait_idle();
    check_init(1'b1, twr);
    rd(ddrinit_pkg::OFS_CFG, 32'h0057_4A20);
    rd(ddrinit_pkg::OFS_RFC, rfc_v);
    rd(ddrinit_pkg::OFS_TIM1, t1);
    rd(ddrinit_pkg::OFS_TIM2, rfc_v);
    rd(ddrinit_pkg::OFS_STAT, 32'h4000_0004);
    check({16'h0, refresh_interval}, rfc_v);
    check({29'h0, read_sample_latency}, 32'h0000_0006);
    check({31'h0, bus_width_select}, 32'h0000_0001);
    check({31'h0, interface_logic_reset}, 32'h0000_0000);
    t1[18:16] = ~twr;
    wr(ddrinit_pkg::OFS_TIM1, t1);
    wr(ddrinit_pkg::OFS_TIM2, ~rfc_v);
    wipe();
    @(posedge clk) soft_rst <= 1'b1;
    @(posedge clk) soft_rst <= 1'b0;
    wait_idle();
    check_init(1'b1, twr);
    rd(ddrinit_pkg::OFS_RFC, rfc_v);
    rd(ddrinit_pkg::OFS_TIM2, rfc_v);
    @(posedge clk) queue_pending <= 1'b1;
    wipe();
    wr(ddrinit_pkg::OFS_CFG, 32'h0057_4A20);
    repeat (3000) @(posedge clk);
    check(32'(cmd_cnt), 32'h0000_0000);
    check({30'h0, req_ready, init_busy}, 32'h0000_0001);
    queue_pending <= 1'b0;
    wait_idle();
    check_init(1'b1, twr);
    @(posedge mem_clk_in);
    repeat (5) @(posedge clk);
    rd_issue <= 1'b1;
    e0 = edge_cnt;
    @(posedge clk) rd_issue <= 1'b0;
    for (n = 0; n < 200 && rd_capture !== 1'b1; n++) @(posedge clk);
    if (n == 200) err_total++;
    check(32'(edge_cnt - e0), 32'h0000_0006);
    test_done();
  end
endmodule : testbench
`default_nettype wire
